/* File: tsc_config_limits.sv */
// Purpose: configuration and limit register bank with conversion sequencing
// Assumes: serial engine delivers pointer and word strobes on this clock
// Notes:   conversion engine is outside; this block starts, aborts and samples it
//
// Functional notes
// - both controls clear: convert continuously, reset default
// - single mode: trigger write runs one conversion
// - shutdown set: no conversion, trigger ignored
// - fault_queue_len selects one, two, four, six faults
// - alarm_polarity clear low-active, set high-active
// - thermostat_mode_sel: comparator clear, interrupt set
// - shutdown_ctrl set stops conversions, clear continuous unless single mode
// - config at pointer 1, fields, resets zero
// - low limit at pointer 2, resets 4b00
// - high limit at pointer 3, resets 5000
// - limits share the temperature result format
// - pointer low three bits select the register
// - shutdown entry aborts conversion, clears alarm, counter
`default_nettype none
module tsc_config_limits
	import tsc_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = CONV_DELAY_CYCLES  // gap between conversions
)(
	// clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        SRST_IN,
	// pointer and word access from the serial engine
	input  wire logic        PTR_WR_IN,
	input  wire logic [7:0]  PTR_DATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic [15:0] REG_WDATA_IN,
	input  wire logic        REG_RD_IN,
	output logic [15:0]      REG_RDATA_OUT,
	// conversion engine
	output logic             CONV_START_OUT,
	output logic             CONV_ABORT_OUT,
	output logic             CONV_BUSY_OUT,
	input  wire logic        CONV_DONE_IN,
	input  wire logic [11:0] CONV_RESULT_IN,
	// open-drain alarm pin
	output logic             ALERT_O_OUT,
	output logic             ALERT_OE_OUT
);
	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [2:0]         pointer;       // selected register
	tsc_cfg_type        cfg;           // upper config byte
	logic [11:0]        low_limit;     // low_temp_limit bits 15:4
	logic [11:0]        high_limit;    // high_temp_limit bits 15:4
	logic [11:0]        last_result;   // newest temperature
	tsc_conv_state_type state;         // sequencer
	logic [DELAY_W-1:0] gap_count;     // idle gap timer
	logic               sd_prev;       // shutdown_ctrl last cycle
	logic               alert_active;  // from the fault queue
	logic               sd_entry;      // rising shutdown_ctrl
	logic               trigger_wr;    // write to trigger pointer
	logic               sample;        // result accepted
	tsc_alarm_ctl_type  alarm_ctl;     // fault queue controls

	assign sd_entry   = cfg.shutdown_ctrl && !sd_prev;
	assign trigger_wr = REG_WR_IN && (pointer == PTR_TRIGGER);
	assign sample     = (state == CS_CONV) && CONV_DONE_IN && !cfg.shutdown_ctrl;
	assign alarm_ctl  = '{fault_queue_len:     cfg.fault_queue_len,
	                      thermostat_mode_sel: cfg.thermostat_mode_sel};

	// word as software sees it at a pointer value
	function automatic logic [15:0] read_word(input logic [2:0] ptr);
		unique case (ptr)
			PTR_TEMP:   read_word = {last_result, 4'h0};
			PTR_CONFIG: read_word = {cfg, 8'h00};
			PTR_LOW:    read_word = {low_limit, 4'h0};
			PTR_HIGH:   read_word = {high_limit, 4'h0};
			default:    read_word = 16'h0000;  // trigger and unused pointers
		endcase
	endfunction : read_word

	////////////////////////////////////////////////////////////////////////////////
	// pointer: only the three low bits matter
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			pointer <= PTR_RESET;
		end else if (PTR_WR_IN) begin
			pointer <= PTR_DATA_IN[2:0];
		end
	end

	// configuration; low byte is never stored so it reads back zero
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			cfg <= CONFIG_RESET[15:CFG_HI_LSB];
		end else if (REG_WR_IN && pointer == PTR_CONFIG) begin
			// reserved bits kept as written; host is expected to send zeros
			cfg <= REG_WDATA_IN[15:CFG_HI_LSB];
		end
	end

	// limit words, nibble 3:0 dropped so it reads as zero
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			low_limit  <= LOW_RESET[15:LIM_LSB];
			high_limit <= HIGH_RESET[15:LIM_LSB];
		end else if (REG_WR_IN) begin
			if (pointer == PTR_LOW) begin
				low_limit <= REG_WDATA_IN[15:LIM_LSB];
			end
			if (pointer == PTR_HIGH) begin
				high_limit <= REG_WDATA_IN[15:LIM_LSB];
			end
		end
	end

	// read data captured on the read strobe and held
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			REG_RDATA_OUT <= 16'h0000;
		end else if (REG_RD_IN) begin
			REG_RDATA_OUT <= read_word(pointer);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shutdown edge tracking
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			sd_prev <= 1'b0;
		end else begin
			sd_prev <= cfg.shutdown_ctrl;
		end
	end

	// conversion sequencer; reset starts a conversion right away
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			state     <= CS_IDLE;
			gap_count <= '0;
		end else if (cfg.shutdown_ctrl) begin
			state     <= CS_IDLE;
			gap_count <= '0;
		end else begin
			unique case (state)
				CS_IDLE: begin
					// continuous starts at once; single mode waits for a trigger
					if (!cfg.single_conversion_ctrl || trigger_wr) begin
						state <= CS_CONV;
					end
				end
				CS_CONV: begin
					if (CONV_DONE_IN) begin
						gap_count <= '0;
						state     <= cfg.single_conversion_ctrl ? CS_IDLE : CS_GAP;
					end
				end
				CS_GAP: begin
					// single mode selected mid-gap drops straight to idle
					if (cfg.single_conversion_ctrl) begin
						state <= CS_IDLE;
					end else if (gap_count == DELAY_W'(DELAY_CYCLES - 1)) begin
						state <= CS_CONV;
					end else begin
						gap_count <= gap_count + DELAY_W'(1);
					end
				end
			endcase
		end
	end

	// engine strobes: start on entering conversion, abort on shutdown entry during a conversion
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			CONV_START_OUT <= 1'b0;
			CONV_ABORT_OUT <= 1'b0;
			CONV_BUSY_OUT  <= 1'b0;
		end else begin
			CONV_START_OUT <= !cfg.shutdown_ctrl && (
				(state == CS_IDLE && (!cfg.single_conversion_ctrl || trigger_wr)) ||
				(state == CS_GAP && !cfg.single_conversion_ctrl &&
				 gap_count == DELAY_W'(DELAY_CYCLES - 1)));
			CONV_ABORT_OUT <= sd_entry && (state == CS_CONV);
			CONV_BUSY_OUT  <= (state == CS_CONV) && !CONV_DONE_IN && !cfg.shutdown_ctrl;
		end
	end

	// newest result kept for the temperature word
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			last_result <= 12'h000;
		end else if (sample) begin
			last_result <= CONV_RESULT_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault queue; limits compare as signed sixteenths of a degree
	tsc_fault_queue u_fault_queue (
		.clk_in           (REF_CLK_IN),
		.srst_in          (SRST_IN),
		.clear_in         (sd_entry),
		.ctl_in           (alarm_ctl),
		.ack_in           (REG_RD_IN),
		.sample_in        (sample),
		.over_high_in     ($signed(CONV_RESULT_IN) >= $signed(high_limit)),
		.under_low_in     ($signed(CONV_RESULT_IN) <  $signed(low_limit)),
		.alert_active_out (alert_active)
	);

	// pin drives low when the alarm level is low, else floats to the pull-up
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			ALERT_O_OUT  <= 1'b0;
			ALERT_OE_OUT <= 1'b0;
		end else begin
			ALERT_O_OUT  <= 1'b0;
			ALERT_OE_OUT <= (alert_active == cfg.alarm_polarity) ? 1'b0 : 1'b1;
		end
	end
endmodule : tsc_config_limits
`default_nettype wire

/* File: tsc_config_limits_chk.sv */
// Purpose: port-level checks of the config/limit bank
// Assumes: one clock, synchronous reset
// Notes:   pointer and config word are mirrored from the strobes
`default_nettype none
module tsc_config_limits_chk
	import tsc_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = 20  // handed on, unused here
)(
	input wire logic        REF_CLK_IN, SRST_IN, PTR_WR_IN, REG_WR_IN, REG_RD_IN,
	input wire logic [7:0]  PTR_DATA_IN,
	input wire logic [15:0] REG_WDATA_IN, REG_RDATA_OUT,
	input wire logic        CONV_START_OUT, CONV_ABORT_OUT, CONV_BUSY_OUT, CONV_DONE_IN,
	input wire logic [11:0] CONV_RESULT_IN,
	input wire logic        ALERT_O_OUT, ALERT_OE_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0]  ptr_q;     // pointer mirror
	logic [15:0] cfg_q;     // config mirror
	logic        one_done;  // single conversion finished, sequencer idle
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (SRST_IN);
	// mirrors follow the same strobes the bank takes
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			ptr_q <= PTR_RESET;
			cfg_q <= 16'h0000;
		end else begin
			if (PTR_WR_IN) ptr_q <= PTR_DATA_IN[2:0];
			if (REG_WR_IN && ptr_q == PTR_CONFIG) cfg_q <= REG_WDATA_IN;
		end
	end
	// idle tracking, only trusted after a finished single conversion
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN || !cfg_q[CFG_OS_BIT] || cfg_q[CFG_SD_BIT] || CONV_START_OUT)
			one_done <= 1'b0;
		else if (CONV_DONE_IN) one_done <= 1'b1;
	end
	sequence s_trig_wr;
		REG_WR_IN && ptr_q == PTR_TRIGGER && one_done && !CONV_BUSY_OUT;
	endsequence
	sequence s_shut_entry;
		$rose(cfg_q[CFG_SD_BIT]) && CONV_BUSY_OUT && !CONV_DONE_IN && !$past(CONV_DONE_IN);
	endsequence
	a_rd_stands: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
		else $error("read data moved without a read");
	a_cfg_low_zero: assert property (
		REG_RD_IN && ptr_q == PTR_CONFIG |=> REG_RDATA_OUT[7:0] == 8'h00)
		else $error("config low byte not zero");
	a_lim_low_zero: assert property (
		REG_RD_IN && ptr_q[2:1] == 2'b01 |=> REG_RDATA_OUT[3:0] == 4'h0)
		else $error("limit low nibble not zero");
	a_unmapped_zero: assert property (
		REG_RD_IN && ptr_q[2] |=> REG_RDATA_OUT == 16'h0000)
		else $error("unmapped read not zero");
	a_shut_no_start: assert property (
		cfg_q[CFG_SD_BIT] && $past(cfg_q[CFG_SD_BIT]) |-> !CONV_START_OUT)
		else $error("start while shut down");
	a_shut_abort: assert property (s_shut_entry |-> ##[0:2] CONV_ABORT_OUT)
		else $error("no abort on shutdown");
	// shut for four samples in a row: the entry clear has reached the pin by now
	a_shut_alert_idle: assert property (
		cfg_q[CFG_SD_BIT] && $past(cfg_q[CFG_SD_BIT]) && $past(cfg_q[CFG_SD_BIT], 2)
		&& $past(cfg_q[CFG_SD_BIT], 3) && $past(cfg_q[CFG_POL_BIT]) == cfg_q[CFG_POL_BIT]
		|-> ALERT_OE_OUT == cfg_q[CFG_POL_BIT])
		else $error("alarm active while shut down");
	a_busy_ends: assert property (CONV_DONE_IN && CONV_BUSY_OUT |-> ##[1:2] !CONV_BUSY_OUT)
		else $error("busy stayed after done");
	a_trig_start: assert property (s_trig_wr |=> CONV_START_OUT)
		else $error("trigger gave no start");
endmodule : tsc_config_limits_chk
bind tsc_config_limits tsc_config_limits_chk #(.DELAY_CYCLES(DELAY_CYCLES)) u_chk (
	.REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN), .PTR_WR_IN(PTR_WR_IN), .REG_WR_IN(REG_WR_IN),
	.REG_RD_IN(REG_RD_IN), .PTR_DATA_IN(PTR_DATA_IN), .REG_WDATA_IN(REG_WDATA_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .CONV_START_OUT(CONV_START_OUT),
	.CONV_ABORT_OUT(CONV_ABORT_OUT), .CONV_BUSY_OUT(CONV_BUSY_OUT), .CONV_DONE_IN(CONV_DONE_IN),
	.CONV_RESULT_IN(CONV_RESULT_IN), .ALERT_O_OUT(ALERT_O_OUT), .ALERT_OE_OUT(ALERT_OE_OUT));
`default_nettype wire

/* File: tsc_config_limits_tb_top.sv */
// Purpose: self-checking bench for the config/limit bank
// Assumes: conversion model answers every start that is not aborted
// Notes:   short conversion gap keeps the run brief
`default_nettype none
module tsc_config_limits_tb_top import tsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst = 1'b1, pwr = 1'b0, rwr = 1'b0, rrd = 1'b0, got;
	logic        done, start, abort, busy, alo, oe;
	logic [7:0]  pd = 8'h00;
	logic [15:0] wd = 16'h0000, rdat, rd_val;
	logic [11:0] res, temp_val = 12'h000;
	int          error_cnt = 0, tests_run = 0, n, dep;
	typedef struct packed {logic [7:0] p; logic [15:0] d; logic [15:0] e;} tsc_row_type;
	tsc_row_type rows [7] = '{'{8'h02, 16'h123f, 16'h1230}, '{8'h03, 16'h7ff5, 16'h7ff0},
		'{8'hfa, 16'h0ab7, 16'h0ab0}, '{8'h0b, 16'h2a0c, 16'h2a00}, '{8'h04, 16'hffff, 16'h0000},
		'{8'h05, 16'h5a5a, 16'h0000}, '{8'h01, 16'h1e00, 16'h1e00}};
	logic [15:0] rstv [3] = '{16'h0000, 16'h4b00, 16'h5000};
	tsc_config_limits #(.DELAY_CYCLES(20)) dut_u (.REF_CLK_IN(clk), .SRST_IN(rst),
		.PTR_WR_IN(pwr), .PTR_DATA_IN(pd), .REG_WR_IN(rwr), .REG_WDATA_IN(wd), .REG_RD_IN(rrd),
		.REG_RDATA_OUT(rdat), .CONV_START_OUT(start), .CONV_ABORT_OUT(abort),
		.CONV_BUSY_OUT(busy), .CONV_DONE_IN(done), .CONV_RESULT_IN(res),
		.ALERT_O_OUT(alo), .ALERT_OE_OUT(oe));
	tsc_conv_model u_conv (.clk_in(clk), .srst_in(rst), .start_in(start), .abort_in(abort),
		.temp_in(temp_val), .done_out(done), .result_out(res));
	always #10 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tk(input int k = 1);
		repeat (k) @(negedge clk);
	endtask : tk
	// pointer then word; strobes last one cycle each
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		pwr = 1'b1; pd = p; tk();
		pwr = 1'b0; rwr = 1'b1; wd = d; tk();
		rwr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] p, output logic [15:0] v);
		pwr = 1'b1; pd = p; tk();
		pwr = 1'b0; rrd = 1'b1; tk();
		rrd = 1'b0; tk();
		v = rdat;
	endtask : rd
	// w: 0 start, 1 done, 2 abort; bounded wait
	task automatic wait_ev(input int w, input int lim, output logic g);
		g = 1'b0;
		for (int i = 0; i < lim && !g; i++) begin
			tk();
			g = ((w == 0) ? start : (w == 1) ? done : abort) === 1'b1;
		end
	endtask : wait_ev
	task automatic quiet(input int k);
		n = 0;
		repeat (k) begin
			tk();
			n += (start === 1'b1);
		end
	endtask : quiet
	// one conversion, then alarm pin drive checked four clocks on
	task automatic alarm_step(input logic exp);
		wait_ev(1, 60, got);
		tk(4);
		chk("alert", 16'(oe), 16'(exp));
	endtask : alarm_step
	task automatic rst_chk();
		rst = 1'b1; tk(16);
		rst = 1'b0;
		wait_ev(0, 4, got);
		chk("reset start", 16'(got), 16'h0001);
		foreach (rstv[i]) begin
			rd(8'(i + 1), rd_val);
			chk("reset value", rd_val, rstv[i]);
		end
	endtask : rst_chk
	task automatic tally_and_finish();
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		tk(20000);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		rst_chk();
		foreach (rows[i]) begin
			wr(rows[i].p, rows[i].d);
			rd(rows[i].p, rd_val);
			chk("row", rd_val, rows[i].e);
		end
		wr(8'h02, 16'h1000); wr(8'h03, 16'h2000);
		// each queue depth: abort mid-conversion, then trip and release
		for (int q = 0; q < 4; q++) begin
			dep = (q == 0) ? 1 : 2 * q;
			wait_ev(0, 60, got); tk(2);
			wr(8'h01, 16'h0100);
			wait_ev(2, 6, got);
			chk("abort", 16'(got), 16'h0001);
			tk(2);
			chk("shut alert", 16'(oe), 16'h0000);
			temp_val = 12'h300;
			wr(8'h01, {3'h0, q[1:0], 11'h000});
			for (int k = 1; k <= dep; k++) alarm_step(k == dep);
			temp_val = 12'h050;
			for (int k = 1; k <= dep; k++) alarm_step(k != dep);
		end
		wr(8'h01, 16'h0400); tk(3);
		chk("polarity", 16'(oe), 16'h0001);
		wr(8'h01, 16'h0100); temp_val = 12'h300;
		wr(8'h01, 16'h0200);
		alarm_step(1'b1);
		rd(8'h00, rd_val); tk(2);
		chk("temp word", rd_val, 16'h3000);
		chk("ack", 16'(oe), 16'h0000);
		alarm_step(1'b0);
		temp_val = 12'h050;
		alarm_step(1'b1);
		chk("pin data", 16'(alo), 16'h0000);
		wr(8'h01, 16'h0100); wr(8'h01, 16'h2000);
		quiet(60);
		chk("single idle", 16'(n), 16'h0000);
		repeat (2) begin
			wr(8'h04, 16'h0000);
			// start pulse stands only in the cycle right after the write
			got = (start === 1'b1);
			chk("trigger", 16'(got), 16'h0001);
			wait_ev(1, 20, got);
			quiet(60);
			chk("one only", 16'(n), 16'h0000);
		end
		wr(8'h01, 16'h2100); wr(8'h04, 16'h0000);
		quiet(60);
		chk("shut trigger", 16'(n), 16'h0000);
		rst_chk();
		tally_and_finish();
	end
endmodule : tsc_config_limits_tb_top
`default_nettype wire

/* File: tsc_conv_model.sv */
// Purpose: conversion engine stand-in for the config/limit bank
// Assumes: shares the bank's clock and reset
// Notes:   result toggles outside done so a stale value never passes
`default_nettype none
module tsc_conv_model #(
	parameter int CONV_CYCLES = 10  // conversion length in clocks
)(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// control from the bank
	input  wire logic        start_in,
	input  wire logic        abort_in,
	input  wire logic [11:0] temp_in,
	// answer
	output logic             done_out,
	output logic [11:0]      result_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;  // clocks left, zero when idle
	initial done_out = 1'b0;
	initial result_out = 12'h000;
	// count a conversion down; abort or reset drops it without done
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		result_out <= ~result_out;
		if (srst_in || abort_in) begin
			cnt <= 0;
		end else if (start_in) begin
			cnt <= CONV_CYCLES;
		end else if (cnt == 1) begin
			cnt <= 0;
			done_out <= 1'b1;
			result_out <= temp_in;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule : tsc_conv_model
`default_nettype wire

/* File: tsc_fault_queue.sv */
// Purpose: consecutive-fault counter and alarm state
// Assumes: sample pulses once per finished conversion
// Notes:   clear has priority; a new alarm beats an acknowledge
`default_nettype none
module tsc_fault_queue
	import tsc_pkg::*;
(
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	// control
	input  wire logic              clear_in,     // shutdown entry
	input  wire tsc_alarm_ctl_type ctl_in,
	input  wire logic              ack_in,       // register read in interrupt behaviour
	// comparison of the newest result
	input  wire logic              sample_in,
	input  wire logic              over_high_in,
	input  wire logic              under_low_in,
	// state
	output logic                   alert_active_out
);
	logic [2:0] count;     // consecutive faults seen
	logic       hunt_low;  // waiting for the low crossing
	logic       fault;     // current result counts as a fault
	logic       trip;      // queue full on this sample

	// depth lookup for the queue length code
	function automatic logic [2:0] fq_depth(input logic [1:0] code);
		unique case (code)
			2'h0: fq_depth = FQ_DEPTH0;
			2'h1: fq_depth = FQ_DEPTH1;
			2'h2: fq_depth = FQ_DEPTH2;
			2'h3: fq_depth = FQ_DEPTH3;
		endcase
	endfunction : fq_depth

	assign fault = hunt_low ? under_low_in : over_high_in;
	assign trip  = sample_in && fault && (count == fq_depth(ctl_in.fault_queue_len) - 3'h1);

	// fault counter, restarts on any in-limit result
	always_ff @(posedge clk_in) begin
		if (srst_in || clear_in) begin
			count <= 3'h0;
		end else if (trip) begin
			count <= 3'h0;
		end else if (sample_in) begin
			count <= fault ? count + 3'h1 : 3'h0;
		end
	end

	// direction of the next crossing we look for
	always_ff @(posedge clk_in) begin
		if (srst_in || clear_in) begin
			hunt_low <= 1'b0;
		end else if (trip) begin
			hunt_low <= ~hunt_low;
		end
	end

	// alarm flag; comparator follows crossings, interrupt latches until read
	always_ff @(posedge clk_in) begin
		if (srst_in || clear_in) begin
			alert_active_out <= 1'b0;
		end else if (trip) begin
			alert_active_out <= ctl_in.thermostat_mode_sel ? 1'b1 : ~hunt_low;
		end else if (ctl_in.thermostat_mode_sel && ack_in) begin
			alert_active_out <= 1'b0;
		end
	end
endmodule : tsc_fault_queue
`default_nettype wire

/* File: tsc_pkg.sv */
// Purpose: shared constants and types for the temperature sensor config/limit bank
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes:   register words are 16 bits, reached by a 3-bit pointer
`default_nettype none
package tsc_pkg;
	// pointer values
	localparam logic [2:0]  PTR_TEMP      = 3'h0;   // temperature result, read only
	localparam logic [2:0]  PTR_CONFIG    = 3'h1;   // device_config
	localparam logic [2:0]  PTR_LOW       = 3'h2;   // low_temp_limit
	localparam logic [2:0]  PTR_HIGH      = 3'h3;   // high_temp_limit
	localparam logic [2:0]  PTR_TRIGGER   = 3'h4;   // one-conversion trigger, write only
	localparam logic [2:0]  PTR_RESET     = 3'h0;   // pointer after reset
	// values after reset
	localparam logic [15:0] CONFIG_RESET  = 16'h0000;
	localparam logic [15:0] LOW_RESET     = 16'h4b00;
	localparam logic [15:0] HIGH_RESET    = 16'h5000;
	// field positions
	localparam int          CFG_SD_BIT    = 8;      // shutdown_ctrl
	localparam int          CFG_TM_BIT    = 9;      // thermostat_mode_sel
	localparam int          CFG_POL_BIT   = 10;     // alarm_polarity
	localparam int          CFG_FQ_LSB    = 11;     // fault_queue_len, 2 bits
	localparam int          CFG_OS_BIT    = 13;     // single_conversion_ctrl
	localparam int          CFG_HI_LSB    = 8;      // writable byte starts here
	localparam int          LIM_LSB       = 4;      // twelve-bit limit sits in 15:4
	// timing: idle gap between continuous conversions
	localparam int          CLK_MHZ       = 50;
	localparam int          CONV_DELAY_US = 53000;
	localparam int          CONV_DELAY_CYCLES = CONV_DELAY_US * CLK_MHZ;
	localparam int          DELAY_W       = 22;     // holds CONV_DELAY_CYCLES
	// fault queue depths per fault_queue_len code
	localparam logic [2:0]  FQ_DEPTH0     = 3'h1;
	localparam logic [2:0]  FQ_DEPTH1     = 3'h2;
	localparam logic [2:0]  FQ_DEPTH2     = 3'h4;
	localparam logic [2:0]  FQ_DEPTH3     = 3'h6;

	// upper config byte as held in the device
	typedef struct packed {
		logic [1:0] reserved;
		logic       single_conversion_ctrl;
		logic [1:0] fault_queue_len;
		logic       alarm_polarity;
		logic       thermostat_mode_sel;
		logic       shutdown_ctrl;
	} tsc_cfg_type;

	// conversion sequencer states
	typedef enum logic [1:0] {
		CS_IDLE,
		CS_CONV,
		CS_GAP
	} tsc_conv_state_type;

	// alarm evaluation controls passed to the fault queue
	typedef struct packed {
		logic [1:0] fault_queue_len;
		logic       thermostat_mode_sel;
	} tsc_alarm_ctl_type;
endpackage : tsc_pkg
`default_nettype wire
